// >>> tb/gpio_edge_irq_regs_tb.sv
// Self-checking bench for the I/O port register block.
`timescale 1ns/1ps
module gpio_edge_irq_regs_tb;
  import gpio_regs_pkg::*;
  logic       clk_i   = 1'b0;
  logic       reset_i = 1'b1;
  logic       sync;
  logic       din;
  logic       dout;
  logic       dout_oe;
  logic [9:0] ext_q   = 10'h000;
  logic [4:0] src_q   = 5'h00;
  logic [9:0] pin_o;
  logic [9:0] pin_oe;
  logic [9:0] pin_lvl;
  int         n_mismatch = 0;
  int         cmp_count  = 0;

  always #50 clk_i = ~clk_i;

  // Pins carry the block's drive where enabled, else the outside level.
  assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & ext_q);

  gpio_edge_irq_regs #(.PINS(10)) gpio_edge_irq_regs_i (
    .clk_i(clk_i), .reset_i(reset_i),
    .serial_frame_sync_i(sync), .serial_data_input_i(din),
    .serial_data_output_o(dout), .serial_data_output_oe_o(dout_oe),
    .io_pin_i(pin_lvl), .io_pin_o(pin_o), .io_pin_oe_o(pin_oe),
    .conv_ready_i(src_q[0]), .touch_plus_x_line_i(src_q[1]),
    .touch_minus_x_line_i(src_q[2]), .tel_clip_i(src_q[3]),
    .aud_clip_i(src_q[4]));

  serial_host serial_host_i (
    .clk_i(clk_i), .dout_i(dout), .oe_i(dout_oe),
    .sync_o(sync), .din_o(din));

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Register write and checked register read over serial frames.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [15:0] r;
    serial_host_i.xfer({1'b0, a, 11'h000}, d, r);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] r;
    serial_host_i.xfer({1'b1, a, 11'h000}, 16'h0000, r);
    check(r, exp);
  endtask

  // Reset values, one unmapped address included.
  task automatic t_reset();
    check({6'h00, pin_oe}, 16'h0000);
    for (int a = 0; a < 6; a++) begin
      rdchk(a[3:0], 16'h0000);
    end
    check({15'h0000, serial_host_i.w2_oe}, 16'h0000);
  endtask

  // Mixed directions: outputs drive data, reads return pin levels.
  task automatic t_port();
    ext_q = 10'h00A;
    wr(ADDR_PIN_DATA, 16'h02A5);
    wr(ADDR_PIN_DIR, 16'h83F0);
    check({6'h00, pin_o}, 16'h02A5);
    check({6'h00, pin_oe}, 16'h03F0);
    rdchk(ADDR_PIN_DIR, 16'h83F0);
    check({15'h0000, serial_host_i.w2_oe}, 16'h0001);
    rdchk(ADDR_PIN_DATA, 16'h02AA);
    wr(ADDR_PIN_DIR, 16'h0000);
    rdchk(ADDR_PIN_DATA, 16'h000A);
    check({15'h0000, serial_host_i.w2_oe}, 16'h0000);
  endtask

  // Edge enables, latching, partial clears and repeated clears.
  task automatic t_edges();
    ext_q = 10'h000;
    wr(ADDR_RISE_EN, 16'hAAAA);
    wr(ADDR_FALL_EN, 16'h5155);
    rdchk(ADDR_FALL_EN, 16'h5155);
    ext_q = 10'h3FF;
    src_q = 5'h1F;
    rdchk(ADDR_IRQ_CS, 16'hAAAA);
    ext_q = 10'h000;
    src_q = 5'h00;
    rdchk(ADDR_IRQ_CS, 16'hFBFF);
    wr(ADDR_IRQ_CS, 16'h00FF);
    rdchk(ADDR_IRQ_CS, 16'hFB00);
    wr(ADDR_IRQ_CS, 16'hFBFF);
    rdchk(ADDR_IRQ_CS, 16'h0000);
    ext_q = 10'h3FF;
    src_q = 5'h1F;
    rdchk(ADDR_IRQ_CS, 16'hAAAA);
    wr(ADDR_IRQ_CS, 16'hFBFF);
    rdchk(ADDR_IRQ_CS, 16'hAAAA);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (8) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    t_reset();
    t_port();
    t_edges();
    tally_and_finish();
  end

  // Watchdog, well beyond the roughly 1740 cycles needed.
  initial begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    tally_and_finish();
  end
endmodule

// >>> tb/gpio_sva.sv
// Checker for serial framing and pin outputs of the port register block.
`timescale 1ns/1ps
module gpio_sva #(
  parameter int unsigned PINS = 10
) (
  input wire logic            clk_i,
  input wire logic            reset_i,
  input wire logic            serial_frame_sync_i,
  input wire logic            serial_data_output_o,
  input wire logic            serial_data_output_oe_o,
  input wire logic [PINS-1:0] io_pin_o,
  input wire logic [PINS-1:0] io_pin_oe_o
);
  logic [6:0] k_q;
  logic [6:0] k_d;

  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // Bit index since frame sync; it saturates past the write commit point.
  assign k_d = serial_frame_sync_i ? 7'h01 :
               (k_q == 7'h00 || k_q == 7'h50) ? k_q : k_q + 7'h01;

  // The index register restarts on every frame sync.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      k_q <= 7'h00;
    end else begin
      k_q <= k_d;
    end
  end

  // Framing of the serial output and timing of register updates.
  property p_idle_float;
    (k_q == 7'h00 || k_q >= 7'h40) |-> !serial_data_output_oe_o;
  endproperty
  property p_word1_low;
    k_q inside {[1:15]} |-> serial_data_output_oe_o && !serial_data_output_o;
  endproperty
  property p_word2_low;
    (k_q inside {[16:31]} && serial_data_output_oe_o) |->
      !serial_data_output_o;
  endproperty
  property p_word2_steady;
    k_q inside {[17:31]} |-> $stable(serial_data_output_oe_o);
  endproperty
  property p_pad_low;
    k_q inside {[48:63]} |-> serial_data_output_oe_o && !serial_data_output_o;
  endproperty
  property p_pin_commit;
    !$stable(io_pin_o) |-> k_q == 7'h44;
  endproperty
  property p_dir_commit;
    !$stable(io_pin_oe_o) |-> k_q == 7'h44;
  endproperty
  property p_reset_quiet;
    $fell(reset_i) |-> io_pin_o == '0 && io_pin_oe_o == '0 &&
      !serial_data_output_oe_o;
  endproperty

  a_idle_float: assert property (p_idle_float)
    else $error("serial output driven outside a frame");
  a_word1_low: assert property (p_word1_low)
    else $error("serial output not low in word one");
  a_word2_low: assert property (p_word2_low)
    else $error("serial output high in word two");
  a_word2_steady: assert property (p_word2_steady)
    else $error("serial drive changed inside word two");
  a_pad_low: assert property (p_pad_low)
    else $error("serial output not low in word four");
  a_pin_commit: assert property (p_pin_commit)
    else $error("pin outputs changed off the commit cycle");
  a_dir_commit: assert property (p_dir_commit)
    else $error("pin enables changed off the commit cycle");
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs not quiet after reset");

  // Main scenarios reached.
  c_read_one: cover property (k_q inside {[32:47]} && serial_data_output_o);
  c_pin_change: cover property (!$stable(io_pin_o));
  c_word2_drive: cover property (k_q == 7'h14 && serial_data_output_oe_o);
endmodule

bind gpio_edge_irq_regs gpio_sva #(.PINS(PINS)) gpio_sva_i (
  .clk_i(clk_i), .reset_i(reset_i),
  .serial_frame_sync_i(serial_frame_sync_i),
  .serial_data_output_o(serial_data_output_o),
  .serial_data_output_oe_o(serial_data_output_oe_o),
  .io_pin_o(io_pin_o), .io_pin_oe_o(io_pin_oe_o));

// >>> tb/serial_host.sv
// Behavioural system controller running 64-bit serial frames.
`timescale 1ns/1ps
module serial_host (
  input  wire logic clk_i,
  input  wire logic dout_i,
  input  wire logic oe_i,
  output logic      sync_o,
  output logic      din_o
);
  // Drive state of the output line seen in word two of the last frame.
  logic w2_oe;

  initial begin
    w2_oe  = 1'b0;
    sync_o = 1'b0;
    din_o  = 1'b0;
  end

  // One frame; read data is taken in word three while the block drives.
  task automatic xfer(input logic [15:0] cmd, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [63:0] bits;
    bits = {cmd, wd, 32'h0};
    rd = 16'h0000;
    for (int k = 0; k < 64; k++) begin
      @(posedge clk_i);
      #1;
      sync_o = (k == 0);
      din_o  = bits[63-k];
      if (k == 20) begin
        w2_oe = oe_i;
      end
      if (k >= 32 && k < 48) begin
        rd[47-k] = oe_i ? dout_i : 1'bx;
      end
    end
    // Idle gap lets a write commit; the data line toggles so it is stale.
    repeat (8) begin
      @(posedge clk_i);
      #1;
      sync_o = 1'b0;
      din_o  = ~din_o;
    end
  endtask
endmodule

// >>> verilog/edge_sampler.sv
// Three-stage input sampler with agreement filter and edge pulses.
`timescale 1ns/1ps
module edge_sampler #(
  parameter int unsigned WIDTH = 16
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  // Raw inputs from outside the clock domain.
  input  wire logic [WIDTH-1:0] async_i,
  // Filtered level and one-cycle edge pulses.
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] rise_o,
  output logic      [WIDTH-1:0] fall_o
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] level_d;

  // A bit only moves once the second and third stages agree on it.
  assign level_d = (s2_q & s3_q) | (level_o & (s2_q | s3_q));

  // Sampler chain; the first stage feeds only the second.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      level_o <= '0;
      rise_o  <= '0;
      fall_o  <= '0;
    end else begin
      s1_q    <= async_i;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_o <= level_d;
      rise_o  <= level_d & ~level_o;
      fall_o  <= ~level_d & level_o;
    end
  end

endmodule

// >>> verilog/gpio_edge_irq_regs.sv
// Ten-pin I/O port with edge interrupt status, reached over the serial bus.
`timescale 1ns/1ps
module gpio_edge_irq_regs
  import gpio_regs_pkg::*;
#(
  parameter int unsigned PINS = PIN_COUNT
) (
  // Serial bit clock and device reset.
  input  wire logic            clk_i,
  input  wire logic            reset_i,
  // Serial interface bus.
  input  wire logic            serial_frame_sync_i,
  input  wire logic            serial_data_input_i,
  output logic                 serial_data_output_o,
  output logic                 serial_data_output_oe_o,
  // General purpose pins.
  input  wire logic [PINS-1:0] io_pin_i,
  output logic      [PINS-1:0] io_pin_o,
  output logic      [PINS-1:0] io_pin_oe_o,
  // Other interrupt sources.
  input  wire logic            conv_ready_i,
  input  wire logic            touch_plus_x_line_i,
  input  wire logic            touch_minus_x_line_i,
  input  wire logic            tel_clip_i,
  input  wire logic            aud_clip_i
);

  // Frame tracking.
  logic             active_q;
  logic [IDX_W-1:0] cnt_q;
  logic [15:0]      shift_q;
  logic [15:0]      cmd_q;
  logic [15:0]      wdata_q;
  logic [15:0]      rd_word_q;
  logic             wr_pend_q;
  logic             sync_prev_q;
  // Write update timer.
  logic             upd_run_q;
  logic [UPD_W-1:0] upd_cnt_q;
  // Registers.
  logic [15:0]      data_q;
  logic [15:0]      dir_q;
  logic [15:0]      rise_en_q;
  logic [15:0]      fall_en_q;
  logic [15:0]      status_q;
  logic [15:0]      clr_last_q;

  // Sampled sources and their edges. Bit ten is a spare slot that never
  // toggles, so its enables and its flag always read as zero.
  logic [15:0]      src_raw;
  logic [15:0]      src_level;
  logic [15:0]      src_rise;
  logic [15:0]      src_fall;

  // Bit index of the current cycle, and of the next one. The output side
  // works one bit ahead, so that its flops present each bit for a full
  // clock period and the controller samples a settled line.
  wire              frame_bit;
  wire [IDX_W-1:0]  bit_idx;
  wire [IDX_W-1:0]  nxt_idx;
  wire              nxt_in_frame;
  wire [1:0]        nxt_word;
  wire [ADDR_W-1:0] cmd_addr;
  wire              cmd_read;
  wire [15:0]       cmd_word;
  wire              sync_fall;
  wire              commit;
  wire [15:0]       clr_pulse;
  wire [15:0]       irq_set;
  wire [15:0]       status_d;
  wire              dout_d;
  wire              oe_d;

  // Register read selection; unmapped addresses read as zero. Only the
  // implemented bits are passed, so a read never shows a bit that no
  // write could have set. The selection is a function so that the field
  // masks live in one place.
  function automatic logic [15:0] read_reg(input logic [ADDR_W-1:0] a,
                                           input logic [15:0] lvl,
                                           input logic [15:0] dir,
                                           input logic [15:0] ren,
                                           input logic [15:0] fen,
                                           input logic [15:0] sts);
    logic [15:0] r;
    r = 16'h0000;
    case (a)
      ADDR_PIN_DATA: r = lvl & PIN_MASK;
      ADDR_PIN_DIR:  r = dir & DIR_MASK;
      ADDR_RISE_EN:  r = ren & IRQ_MASK;
      ADDR_FALL_EN:  r = fen & IRQ_MASK;
      ADDR_IRQ_CS:   r = sts & IRQ_MASK;
      default:       r = 16'h0000;
    endcase
    return r;
  endfunction

  // Source vector: pins low, bit ten unused, then the five other sources.
  // Its bit order matches the enable and status registers, so one mask
  // and one set of edge terms serves every source alike.
  assign src_raw = {aud_clip_i, tel_clip_i, touch_minus_x_line_i,
                    touch_plus_x_line_i, conv_ready_i,
                    {(SRC_CONV - PINS){1'b0}}, io_pin_i};

  // All sources pass the three-stage sampler before edge detection. The
  // pins and the analogue status lines are not timed to the serial clock,
  // so a single flop could pass on a metastable value, and a one-cycle
  // glitch would otherwise count as two edges.
  edge_sampler #(
    .WIDTH (16)
  ) u_sampler (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i (src_raw),
    .level_o (src_level),
    .rise_o  (src_rise),
    .fall_o  (src_fall)
  );

  // Frame position decode; a sampled sync marks bit zero. The sync level
  // is used directly rather than through the counter, so bit zero needs
  // no earlier state and back-to-back frames restart cleanly. The read
  // flag and address come from the latched command word.
  assign frame_bit    = serial_frame_sync_i | active_q;
  assign bit_idx      = serial_frame_sync_i ? '0 : cnt_q;
  assign nxt_idx      = bit_idx + 7'h01;
  assign nxt_in_frame = frame_bit && (nxt_idx < IDX_W'(FRAME_BITS));
  assign nxt_word     = nxt_idx[5:4];
  assign cmd_word     = {shift_q[14:0], serial_data_input_i};
  assign cmd_addr     = cmd_q[CMD_ADDR_HI:CMD_ADDR_LO];
  assign cmd_read     = cmd_q[CMD_READ_BIT];

  // Frame counter runs from the sync bit to the last bit of the frame.
  // A sync seen in mid-frame restarts the count; the controller owns the
  // framing and the block simply follows it.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      active_q <= 1'b0;
      cnt_q    <= '0;
    end else if (serial_frame_sync_i) begin
      active_q <= 1'b1;
      cnt_q    <= 7'h01;
    end else if (active_q) begin
      active_q <= (cnt_q != IDX_W'(FRAME_BITS - 1));
      cnt_q    <= cnt_q + 7'h01;
    end
  end

  // Input bits shift in MSB first; words latch at their last bit. The
  // last bit is taken straight from the input pin, so each word is whole
  // in the very cycle that ends it and no extra cycle is lost.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      shift_q <= 16'h0000;
      cmd_q   <= 16'h0000;
      wdata_q <= 16'h0000;
    end else if (frame_bit) begin
      shift_q <= cmd_word;
      if (bit_idx == IDX_W'(WORD_A_LAST)) begin
        cmd_q <= cmd_word;
      end
      if (bit_idx == IDX_W'(WORD_B_LAST)) begin
        wdata_q <= cmd_word;
      end
    end
  end

  // Read data is captured one bit early so its MSB leaves on time. The
  // snapshot stays frozen for the whole read word, so a flag that sets
  // while the word shifts out shows in the next read, never half-way.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_word_q <= 16'h0000;
    end else if (frame_bit && bit_idx == IDX_W'(RD_LOAD_BIT)) begin
      rd_word_q <= read_reg(cmd_addr, src_level, dir_q, rise_en_q,
                            fall_en_q, status_q);
    end
  end

  // Serial output: read word in word three, word two per drive bit.
  // Outside a frame and in bit zero the line is released, so another
  // device on the same bus can own it between frames. The command and
  // pad words are driven low to keep the line from floating.
  assign dout_d = nxt_in_frame && (nxt_word == WORD_RDATA) &&
                  rd_word_q[~nxt_idx[3:0]];
  assign oe_d   = nxt_in_frame &&
                  ((nxt_word != WORD_WDATA) || dir_q[DRIVE_LOW_BIT]);

  // Output flops for the serial data line. Both leave reset released,
  // so the bus is not fought over while the device comes up.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      serial_data_output_o    <= 1'b0;
      serial_data_output_oe_o <= 1'b0;
    end else begin
      serial_data_output_o    <= dout_d;
      serial_data_output_oe_o <= oe_d;
    end
  end

  // A write stays pending from its data word until the update instant.
  // A read frame that arrives first clears it, so an abandoned write
  // never lands later on the register that the read addressed.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_pend_q <= 1'b0;
    end else if (frame_bit && bit_idx == IDX_W'(WORD_B_LAST)) begin
      wr_pend_q <= ~cmd_read;
    end else if (commit) begin
      wr_pend_q <= 1'b0;
    end
  end

  // Update timer starts on the falling edge of frame sync. A new frame
  // restarts it, so a write lands only once the whole update delay has
  // passed since the last sync fall; frames sent closer than that hold it off.
  assign sync_fall = sync_prev_q & ~serial_frame_sync_i;
  assign commit    = upd_run_q && wr_pend_q &&
                     (upd_cnt_q == UPD_W'(UPDATE_CYCLES));

  // Counts clocks from the sync fall; the write lands on the last one.
  // The timer stops one count past its end value, so it can never wrap round into a
  // second commit of the same word.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync_prev_q <= 1'b0;
      upd_run_q   <= 1'b0;
      upd_cnt_q   <= '0;
    end else begin
      sync_prev_q <= serial_frame_sync_i;
      if (sync_fall) begin
        upd_run_q <= 1'b1;
        upd_cnt_q <= 7'h01;
      end else if (upd_run_q) begin
        upd_run_q <= (upd_cnt_q != UPD_W'(UPDATE_CYCLES));
        upd_cnt_q <= upd_cnt_q + 7'h01;
      end
    end
  end

  // Control registers; only implemented bits hold a value. The status
  // address is handled by the clear logic below, not here, and writes to
  // unmapped addresses are ignored.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      data_q    <= REG_RESET;
      dir_q     <= REG_RESET;
      rise_en_q <= REG_RESET;
      fall_en_q <= REG_RESET;
    end else if (commit) begin
      case (cmd_addr)
        ADDR_PIN_DATA: data_q    <= wdata_q & PIN_MASK;
        ADDR_PIN_DIR:  dir_q     <= wdata_q & DIR_MASK;
        ADDR_RISE_EN:  rise_en_q <= wdata_q & IRQ_MASK;
        ADDR_FALL_EN:  fall_en_q <= wdata_q & IRQ_MASK;
        default: begin
        end
      endcase
    end
  end

  // Pin drivers follow the data and direction registers. They are
  // flopped once more so that every top-level output comes from a
  // register, at the cost of one clock of latency after the update.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      io_pin_o    <= '0;
      io_pin_oe_o <= '0;
    end else begin
      io_pin_o    <= data_q[PINS-1:0];
      io_pin_oe_o <= dir_q[PINS-1:0];
    end
  end

  // Clear pulses fire only on a zero-to-one change of a written bit.
  // Software that wants to clear a flag twice must write a zero in
  // between; writing the same word again leaves every flag alone.
  assign clr_pulse = (commit && cmd_addr == ADDR_IRQ_CS) ?
                     (wdata_q & ~clr_last_q & IRQ_MASK) :
                     16'h0000;

  // Enabled edges set flags; pins, converter, touch lines and clips alike.
  // With both enables of a source clear, its edges are simply lost; they
  // are not remembered for a later enable.
  assign irq_set = ((src_rise & rise_en_q) |
                    (src_fall & fall_en_q)) &
                   IRQ_MASK;

  // Flags are sticky, and a set in the clearing cycle wins. Losing an
  // edge that arrives together with its clear would hide an event from
  // software, while a spare flag only costs one more read.
  for (genvar b = 0; b < 16; b++) begin : g_flag
    assign status_d[b] = irq_set[b] | (status_q[b] & ~clr_pulse[b]);
  end

  // Status flags and the last written clear value. The clear value is
  // kept so that the next write can be compared with it bit by bit.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      status_q   <= REG_RESET;
      clr_last_q <= REG_RESET;
    end else begin
      status_q <= status_d;
      if (commit && cmd_addr == ADDR_IRQ_CS) begin
        clr_last_q <= wdata_q & IRQ_MASK;
      end
    end
  end

endmodule

// >>> verilog/gpio_regs_pkg.sv
// Constants shared by the I/O port register block and its testbench.
package gpio_regs_pkg;

  // Serial frame geometry, counted in serial bit clocks.
  localparam int unsigned FRAME_BITS   = 64;
  localparam int unsigned WORD_BITS    = 16;
  localparam int unsigned WORD_A_LAST  = 15;
  localparam int unsigned WORD_B_LAST  = 31;
  localparam int unsigned RD_LOAD_BIT  = 30;
  localparam int unsigned IDX_W        = 7;

  // Frame words, selected by bits 5:4 of the bit index.
  localparam logic [1:0] WORD_CMD      = 2'h0;
  localparam logic [1:0] WORD_WDATA    = 2'h1;
  localparam logic [1:0] WORD_RDATA    = 2'h2;

  // Command word fields: read flag and register address.
  localparam int unsigned CMD_READ_BIT = 15;
  localparam int unsigned CMD_ADDR_HI  = 14;
  localparam int unsigned CMD_ADDR_LO  = 11;
  localparam int unsigned ADDR_W       = 4;

  // Register addresses.
  localparam logic [3:0] ADDR_PIN_DATA = 4'h0;
  localparam logic [3:0] ADDR_PIN_DIR  = 4'h1;
  localparam logic [3:0] ADDR_RISE_EN  = 4'h2;
  localparam logic [3:0] ADDR_FALL_EN  = 4'h3;
  localparam logic [3:0] ADDR_IRQ_CS   = 4'h4;

  // Field positions and implemented-bit masks.
  localparam int unsigned PIN_COUNT    = 10;
  localparam int unsigned DRIVE_LOW_BIT = 15;
  localparam int unsigned SRC_CONV     = 11;
  localparam int unsigned SRC_TPX      = 12;
  localparam int unsigned SRC_TMX      = 13;
  localparam int unsigned SRC_TCLIP    = 14;
  localparam int unsigned SRC_ACLIP    = 15;
  localparam logic [15:0] PIN_MASK     = 16'h03FF;
  localparam logic [15:0] DIR_MASK     = 16'h83FF;
  localparam logic [15:0] IRQ_MASK     = 16'hFBFF;

  // Reset values.
  localparam logic [15:0] REG_RESET    = 16'h0000;

  // Write update delay, in serial clock periods after frame sync falls.
  localparam int unsigned UPDATE_TSIB  = 65;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned UPDATE_CYCLES =
    (UPDATE_TSIB * CLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned UPD_W        = 7;

endpackage
